// file: serial_flash_powerup_state.v
`timescale 1ns/100ps
`include "flash_powerup_map.vh"
module serial_flash_powerup_state #(
   parameter CNT_W = 20,
   parameter WRITE_DELAY = `WRITE_DELAY_CYCLES
) (
   input wire clk_sys_i,
   input wire arst_n_i,
   input wire clk_en_i,
   input wire reset_release_threshold_i,
   input wire sel_n_i,
   input wire sck_i,
   input wire si_i,
   input wire so_data_i,
   input wire so_drive_req_i,
   output wire so_o,
   output wire so_oe_o,
   output reg spi_mode_o,
   output reg standby_o,
   output reg cmd_start_o,
   output reg sck_rise_o,
   output reg sck_fall_o,
   output reg si_bit_o,
   output wire selected_o,
   output reg write_allowed_o
);
   // =====================================================
   // state codes and constants
   localparam [1:0] ST_RESET = `ST_RESET;
   localparam [1:0] ST_STANDBY = `ST_STANDBY;
   localparam [1:0] ST_SELECTED = `ST_SELECTED;
   localparam integer WCNT_LAST_I = WRITE_DELAY - 1;
   // last count of the hold-off, cut to the counter width on purpose
   localparam [CNT_W-1:0] WCNT_LAST = WCNT_LAST_I[CNT_W-1:0];

   // =====================================================
   // declarations
   wire sel_n;
   wire sck;
   wire si_s;
   wire por_ok;
   wire sel_fall;
   wire sck_rise;
   wire sck_fall;
   reg sel_d1_q;
   reg sck_d1_q;
   reg [1:0] state_q;
   reg [CNT_W-1:0] wcnt_q;
   reg so_oe_q;
   reg so_q;

   // =====================================================
   // pin synchronisers; idle levels at reset so no pin looks active
   pin_sync #(
      .RESET_VAL(1'b1)
   ) u_sel_sync (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .clk_en_i(clk_en_i),
      .pin_i(sel_n_i),
      .sync_o(sel_n)
   );

   pin_sync #(
      .RESET_VAL(1'b1)
   ) u_sck_sync (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .clk_en_i(clk_en_i),
      .pin_i(sck_i),
      .sync_o(sck)
   );

   pin_sync #(
      .RESET_VAL(1'b0)
   ) u_si_sync (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .clk_en_i(clk_en_i),
      .pin_i(si_i),
      .sync_o(si_s)
   );

   // supply good starts low, so a reset always passes through the reset state
   pin_sync #(
      .RESET_VAL(1'b0)
   ) u_por_sync (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .clk_en_i(clk_en_i),
      .pin_i(reset_release_threshold_i),
      .sync_o(por_ok)
   );

   // =====================================================
   // edge detectors; reset to idle pin levels so reset makes no false edge
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sel_d1_q <= 1'b1;
         sck_d1_q <= 1'b1;
      end else if (clk_en_i) begin
         sel_d1_q <= sel_n;
         sck_d1_q <= sck;
      end
   end
   assign sel_fall = sel_d1_q & ~sel_n;
   assign sck_rise = sck & ~sck_d1_q;
   assign sck_fall = ~sck & sck_d1_q;

   // =====================================================
   // state machine
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= ST_RESET;
         spi_mode_o <= `MODE_3; // RL1
         standby_o <= 1'b0;
         cmd_start_o <= 1'b0;
         sck_rise_o <= 1'b0;
         sck_fall_o <= 1'b0;
         si_bit_o <= 1'b0;
      end else if (clk_en_i) begin
         cmd_start_o <= 1'b0;
         sck_rise_o <= 1'b0;
         sck_fall_o <= 1'b0;
         case (state_q)
            ST_RESET: begin
               // supply below threshold: hold everything, ignore the link
               spi_mode_o <= `MODE_3; // RL1
               standby_o <= 1'b0; // RL6
               if (por_ok) begin
                  state_q <= ST_STANDBY; // RL7
                  standby_o <= 1'b1;
               end
            end
            ST_STANDBY: begin
               // a select already low at release is no edge and starts nothing
               if (sel_fall) begin
                  state_q <= ST_SELECTED; // RL3
                  spi_mode_o <= sck ? `MODE_3 : `MODE_0; // RL4
                  cmd_start_o <= 1'b1;
                  standby_o <= 1'b0;
               end
            end
            ST_SELECTED: begin
               if (sel_n) begin
                  state_q <= ST_STANDBY; // RL9
                  standby_o <= 1'b1;
               end else begin
                  sck_rise_o <= sck_rise;
                  sck_fall_o <= sck_fall;
                  if (sck_rise) begin
                     si_bit_o <= si_s;
                  end
               end
            end
            default: begin
               state_q <= ST_RESET;
            end
         endcase
         // supply loss wins over a select edge taken in the same cycle
         if (!por_ok) begin
            state_q <= ST_RESET; // RL6
            standby_o <= 1'b0;
            cmd_start_o <= 1'b0;
         end
      end
   end

   // =====================================================
   // serial output: driven only inside a frame and only when asked
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         so_oe_q <= 1'b0; // RL2
         so_q <= 1'b0;
      end else if (clk_en_i) begin
         if (!por_ok || state_q != ST_SELECTED || sel_n) begin
            so_oe_q <= 1'b0; // RL9
         end else begin
            so_oe_q <= so_drive_req_i;
            so_q <= so_data_i;
         end
      end
   end
   // gating with the synced select turns the output off a cycle earlier
   assign so_oe_o = so_oe_q & ~sel_n;
   assign so_o = so_q;
   assign selected_o = (state_q == ST_SELECTED);

   // =====================================================
   // program/erase hold-off, counted from supply good, not from a command
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wcnt_q <= {CNT_W{1'b0}};
         write_allowed_o <= 1'b0;
      end else if (clk_en_i) begin
         if (!por_ok) begin
            wcnt_q <= {CNT_W{1'b0}};
            write_allowed_o <= 1'b0;
         end else if (wcnt_q < WCNT_LAST) begin
            wcnt_q <= wcnt_q + 1'b1; // RL8
         end else begin
            write_allowed_o <= 1'b1; // RL8
         end
      end
   end
endmodule // serial_flash_powerup_state

// =====================================================
// two-flop synchroniser for one pin
module pin_sync #(
   parameter [0:0] RESET_VAL = 1'b0
) (
   input wire clk_sys_i,
   input wire arst_n_i,
   input wire clk_en_i,
   input wire pin_i,
   output wire sync_o
);
   reg [1:0] sync_q;
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync_q <= {2{RESET_VAL}};
      end else if (clk_en_i) begin
         sync_q <= {sync_q[0], pin_i};
      end
   end
   // only the second flop is read; the first may still be settling
   assign sync_o = sync_q[1];
endmodule // pin_sync

// file: flash_powerup_map.vh
// Contract
// (RL1) start in mode 3 after power or reset
// (RL2) serial output undriven after power or reset
// (RL3) command starts only after select falling edge
// (RL4) select fall samples idle clock picking mode
// (RL5) host waits 70 us before first select
// (RL6) power-on reset holds device, ignores commands
// (RL7) reset release enters standby, ready for command
// (RL8) first program or erase waits 3 ms
// (RL9) select high ignores clock, input, output off
`ifndef FLASH_POWERUP_MAP_VH
`define FLASH_POWERUP_MAP_VH
// =====================================================
// modes and states
`define MODE_0 1'b0
`define MODE_3 1'b1
`define ST_RESET 2'h0
`define ST_STANDBY 2'h1
`define ST_SELECTED 2'h2
// =====================================================
// timing
`define CLK_PERIOD_NS 10
`define SUPPLY_TO_SELECT_WAIT_US 70
`define POWERUP_WRITE_DELAY_MS 3
`define WRITE_DELAY_CYCLES ((`POWERUP_WRITE_DELAY_MS * 1000000) / `CLK_PERIOD_NS)
`define SELECT_WAIT_CYCLES ((`SUPPLY_TO_SELECT_WAIT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: flash_chk_properties.sv
`timescale 1ns/100ps
module flash_chk #(parameter WRITE_DELAY = 50) (
   input wire clk_sys_i, input wire arst_n_i, input wire reset_release_threshold_i,
   input wire sel_n_i, input wire sck_i, input wire so_oe_o, input wire spi_mode_o,
   input wire standby_o, input wire cmd_start_o, input wire sck_rise_o, input wire sck_fall_o,
   input wire selected_o, input wire write_allowed_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   // cycles with supply good; cleared at once, so only rising edges are judged early
   logic [19:0] hi_q;
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
      if (!arst_n_i) hi_q <= 20'h0;
      else hi_q <= reset_release_threshold_i ? hi_q + 20'h1 : 20'h0;
   // ====================
   // properties
   a_oe_select: assert property (so_oe_o |-> !$past(sel_n_i, 2))
      else $error("output driven without select");
   a_start_ready: assert property (cmd_start_o |-> selected_o && $past(standby_o))
      else $error("start outside standby");
   a_mode_pick: assert property (cmd_start_o |-> spi_mode_o == $past(sck_i, 3))
      else $error("mode differs from idle clock");
   a_reset_mode: assert property ($rose(standby_o) && hi_q < 20'h8 |-> spi_mode_o)
      else $error("mode not 3 after reset");
   a_ready_entry: assert property ($rose(reset_release_threshold_i) |-> ##[2:4] standby_o)
      else $error("no standby after release");
   a_por_hold: assert property (!reset_release_threshold_i [*2] |->
      ##3 !standby_o && !cmd_start_o && !write_allowed_o)
      else $error("active while supply low");
   a_write_early: assert property ($rose(write_allowed_o) |-> hi_q >= WRITE_DELAY)
      else $error("write allowed too early");
   a_write_late: assert property (hi_q == WRITE_DELAY + 8 |-> write_allowed_o)
      else $error("write hold-off too long");
   a_idle_quiet: assert property (sel_n_i [*5] |-> !sck_rise_o && !sck_fall_o)
      else $error("clock edge seen while deselected");
   c_mode0: cover property (cmd_start_o && !spi_mode_o);
   c_mode3: cover property (cmd_start_o && spi_mode_o);
   c_write: cover property ($rose(write_allowed_o));
endmodule // flash_chk
bind serial_flash_powerup_state flash_chk #(.WRITE_DELAY(WRITE_DELAY)) u_chk (
   .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
   .reset_release_threshold_i(reset_release_threshold_i), .sel_n_i(sel_n_i), .sck_i(sck_i),
   .so_oe_o(so_oe_o), .spi_mode_o(spi_mode_o), .standby_o(standby_o),
   .cmd_start_o(cmd_start_o), .sck_rise_o(sck_rise_o), .sck_fall_o(sck_fall_o),
   .selected_o(selected_o), .write_allowed_o(write_allowed_o));

// file: host_spi.sv
`timescale 1ns/100ps
module host_spi (
   input wire clk_sys_i,
   output logic sel_n_o = 1'b1,
   output logic sck_o = 1'b1,
   output logic si_o = 1'b0
);
   // clock idles at the chosen level and stands still outside frames; 80 ns period
   task automatic frame(input logic idle, input int bits);
      sck_o <= idle;
      repeat (6) @(posedge clk_sys_i);
      sel_n_o <= 1'b0;
      for (int i = 0; i < 2 * bits; i++) begin
         repeat (4) @(posedge clk_sys_i);
         sck_o <= ~sck_o;
         if (sck_o) si_o <= ~si_o;
      end
      repeat (6) @(posedge clk_sys_i);
      sel_n_o <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
   endtask
endmodule // host_spi

// file: tb.sv
`timescale 1ns/100ps
`include "flash_powerup_map.vh"
module tb;
   localparam int WD = 50;
   logic clk_sys_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic supply_ok = 1'b1;
   logic so_req = 1'b0;
   logic so_dat = 1'b0;
   wire sel_n, sck, si, so, so_oe, mode, standby, sel, wr, si_bit;
   int fails = 0;
   int cmp_count = 0;
   int n;
   initial forever #5 clk_sys_i = ~clk_sys_i;
   host_spi u_host (.clk_sys_i(clk_sys_i), .sel_n_o(sel_n), .sck_o(sck), .si_o(si));
   serial_flash_powerup_state #(.WRITE_DELAY(WD)) u_dut (.clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i), .clk_en_i(1'b1), .reset_release_threshold_i(supply_ok),
      .sel_n_i(sel_n), .sck_i(sck), .si_i(si), .so_data_i(so_dat), .so_drive_req_i(so_req),
      .so_o(so), .so_oe_o(so_oe), .spi_mode_o(mode), .standby_o(standby), .cmd_start_o(),
      .sck_rise_o(), .sck_fall_o(), .si_bit_o(si_bit), .selected_o(sel), .write_allowed_o(wr));
   task automatic chk(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t value mismatch", $time);
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic t_power();
      repeat (4) @(posedge clk_sys_i);
      chk(standby, 1'b1);
      chk(mode, `MODE_3);
      chk(so_oe, 1'b0);
      repeat (`SELECT_WAIT_CYCLES) @(posedge clk_sys_i);
      $display("t_power done");
   endtask
   task automatic t_frames();
      for (int k = 0; k < 3; k++) begin
         so_req <= 1'b1;
         so_dat <= k[0];
         fork
            u_host.frame(k[0], 2 + k);
            begin
               repeat (18) @(posedge clk_sys_i);
               chk(sel, 1'b1);
               chk(so_oe, 1'b1);
            end
         join
         chk(mode, k[0] ? `MODE_3 : `MODE_0);
         chk(so_oe, 1'b0);
         chk(so, k[0]);
         chk(si_bit, k != 2);
      end
      $display("t_frames done");
   endtask
   task automatic t_arst();
      arst_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      chk(mode, `MODE_3);
      chk(so_oe, 1'b0);
      arst_n_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      chk(standby, 1'b0);
      repeat (2) @(posedge clk_sys_i);
      chk(standby, 1'b1);
      chk(mode, `MODE_3);
      $display("t_arst done");
   endtask
   task automatic t_por();
      supply_ok <= 1'b0;
      u_host.frame(1'b0, 2);
      chk(standby, 1'b0);
      chk(mode, `MODE_3);
      chk(wr, 1'b0);
      supply_ok <= 1'b1;
      for (n = 0; n < WD + 20 && wr !== 1'b1; n++) @(posedge clk_sys_i);
      if (wr !== 1'b1) begin
         fails++;
         $display("CHECK FAILED %0t write hold-off never ended", $time);
      end
      chk(n >= WD && n <= WD + 4, 1'b1);
      chk(standby, 1'b1);
      $display("t_por done");
   endtask
   initial begin
      repeat (20) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      t_power();
      t_frames();
      t_arst();
      t_por();
      conclude();
   end
endmodule // tb
